// [dac_ctrl_pkg.sv]
/*
  Shared constants and types for the dual converter register control.
  Assumes an 8-bit special-function-register write/read port on the core clock.
*/
package dac_ctrl_pkg;
  // register addresses in the special-function-register space
  localparam logic [7:0] ADDR_CODE0_LOW = 8'hF9;
  localparam logic [7:0] ADDR_CODE0_HIGH = 8'hFA;
  localparam logic [7:0] ADDR_CODE1_LOW = 8'hFB;
  localparam logic [7:0] ADDR_CODE1_HIGH = 8'hFC;
  localparam logic [7:0] ADDR_CONTROL = 8'hFD;
  // values after power-on
  localparam logic [7:0] RESET_CONTROL = 8'h04;
  localparam logic [7:0] RESET_CODE_BYTE = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  // control field positions
  localparam int unsigned BIT_MODE8 = 7;
  localparam int unsigned BIT_SPAN1 = 6;
  localparam int unsigned BIT_SPAN0 = 5;
  localparam int unsigned BIT_OUTPUT_ZERO_FORCE_ONE = 4;
  localparam int unsigned BIT_OUTPUT_ZERO_FORCE_ZERO = 3;
  localparam int unsigned BIT_SYNC = 2;
  localparam int unsigned BIT_PWR1 = 1;
  localparam int unsigned BIT_PWR0 = 0;
  localparam int unsigned CODE_W = 12;

  // signals toward the two analog converter cores
  typedef struct packed {
    logic [CODE_W-1:0] code1;
    logic [CODE_W-1:0] code0;
    logic [1:0] span_supply;
    logic [1:0] zero_force;
    logic [1:0] power_on;
    logic [1:0] out_enable;
    logic [1:0] bypass;
  } dac_drive_type;

  typedef struct packed {
    logic [7:0] control;
    logic [7:0] low0;
    logic [7:0] high0;
    logic [7:0] low1;
    logic [7:0] high1;
    logic [7:0] rdata;
    dac_drive_type drive;
  } ctrl_state_type;
endpackage

// [dual_dac_register_control.sv]
/*
  Register-side control for two 12-bit voltage-output converters: five
  special-function registers, code latching and update timing, and the
  span, clear, power and buffer-bypass controls toward the analog cores.
  Assumes the core drives the register port synchronously to i_core_clk
  and that i_buffer_bypass comes from the system configuration register
  on the same clock.
*/
`timescale 1ns/1ns
module dual_dac_register_control (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic i_buffer_bypass,
  output logic [7:0] o_sfr_rdata,
  output dac_ctrl_pkg::dac_drive_type o_drive
);
  import dac_ctrl_pkg::*;

  logic rst_meta_r;
  logic rst_n;
  ctrl_state_type s_r;
  ctrl_state_type s_nxt;

  // reset asserts at once, releases after two clean edges
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end

  // code as the core sees it; 8-bit codes are scaled up to full span
  function automatic logic [CODE_W-1:0] form_code(input logic mode8, input logic [7:0] lo,
                                                   input logic [7:0] hi);
    if (mode8) begin
      form_code = {lo, 4'h0};
    end else begin
      form_code = {hi[3:0], lo};
    end
  endfunction

  logic wr_ctrl;
  logic wr_low0;
  logic wr_low1;
  logic sync_rise;
  assign wr_ctrl = i_sfr_wr && (i_sfr_addr == ADDR_CONTROL);
  assign wr_low0 = i_sfr_wr && (i_sfr_addr == ADDR_CODE0_LOW);
  assign wr_low1 = i_sfr_wr && (i_sfr_addr == ADDR_CODE1_LOW);
  assign sync_rise = wr_ctrl && !s_r.control[BIT_SYNC] && i_sfr_wdata[BIT_SYNC];

  always_comb begin
    s_nxt = s_r;
    if (i_sfr_wr) begin
      case (i_sfr_addr)
        ADDR_CODE0_LOW: s_nxt.low0 = i_sfr_wdata;
        ADDR_CODE0_HIGH: s_nxt.high0 = i_sfr_wdata;
        ADDR_CODE1_LOW: s_nxt.low1 = i_sfr_wdata;
        ADDR_CODE1_HIGH: s_nxt.high1 = i_sfr_wdata;
        ADDR_CONTROL: s_nxt.control = i_sfr_wdata;
        default: s_nxt.control = s_r.control;
      endcase
    end
    // a low byte write only moves the output while updates follow writes
    if (s_r.control[BIT_SYNC] && wr_low0) begin
      s_nxt.drive.code0 = form_code(s_r.control[BIT_MODE8], i_sfr_wdata, s_r.high0);
    end
    if (s_r.control[BIT_SYNC] && wr_low1) begin
      s_nxt.drive.code1 = form_code(s_r.control[BIT_MODE8], i_sfr_wdata, s_r.high1);
    end
    // both staged codes go out on the same edge when sync is raised
    if (sync_rise) begin
      s_nxt.drive.code0 = form_code(i_sfr_wdata[BIT_MODE8], s_r.low0, s_r.high0);
      s_nxt.drive.code1 = form_code(i_sfr_wdata[BIT_MODE8], s_r.low1, s_r.high1);
    end
    s_nxt.drive.span_supply[1] = s_nxt.control[BIT_SPAN1];
    s_nxt.drive.span_supply[0] = s_nxt.control[BIT_SPAN0];
    s_nxt.drive.zero_force[1] = !s_nxt.control[BIT_OUTPUT_ZERO_FORCE_ONE];
    s_nxt.drive.zero_force[0] = !s_nxt.control[BIT_OUTPUT_ZERO_FORCE_ZERO];
    s_nxt.drive.power_on[1] = s_nxt.control[BIT_PWR1];
    s_nxt.drive.power_on[0] = s_nxt.control[BIT_PWR0];
    // a powered-down output floats; the pull-down sits outside the chip
    s_nxt.drive.out_enable = {s_nxt.control[BIT_PWR1], s_nxt.control[BIT_PWR0]};
    // bypass is refused on the supply span, where the core cannot work unbuffered
    s_nxt.drive.bypass[1] = i_buffer_bypass && !s_nxt.control[BIT_SPAN1];
    s_nxt.drive.bypass[0] = i_buffer_bypass && !s_nxt.control[BIT_SPAN0];
    case (i_sfr_addr)
      ADDR_CODE0_LOW: s_nxt.rdata = s_r.low0;
      ADDR_CODE0_HIGH: s_nxt.rdata = s_r.high0;
      ADDR_CODE1_LOW: s_nxt.rdata = s_r.low1;
      ADDR_CODE1_HIGH: s_nxt.rdata = s_r.high1;
      ADDR_CONTROL: s_nxt.rdata = s_r.control;
      default: s_nxt.rdata = UNMAPPED_READ;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
      s_r.control <= RESET_CONTROL;
      s_r.low0 <= RESET_CODE_BYTE;
      s_r.high0 <= RESET_CODE_BYTE;
      s_r.low1 <= RESET_CODE_BYTE;
      s_r.high1 <= RESET_CODE_BYTE;
      s_r.drive.zero_force <= 2'h3;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_sfr_rdata = s_r.rdata;
  assign o_drive = s_r.drive;

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!rst_n);

  AST_LOW_WRITE_12BIT: assert property (
    s_r.control[BIT_SYNC] && !s_r.control[BIT_MODE8] && wr_low0 && !wr_ctrl
    |=> o_drive.code0 == {$past(s_r.high0[3:0]), $past(i_sfr_wdata)})
    else $error("converter 0 code not taken on low byte write");
  AST_EIGHT_BIT_MODE: assert property (
    s_r.control[BIT_SYNC] && s_r.control[BIT_MODE8] && wr_low1
    |=> o_drive.code1 == {$past(i_sfr_wdata), 4'h0})
    else $error("8-bit code not formed from low byte");
  AST_SPAN_ONE: assert property (
    wr_ctrl |=> o_drive.span_supply[1] == $past(i_sfr_wdata[BIT_SPAN1]))
    else $error("converter 1 span does not follow control");
  AST_SPAN_ZERO: assert property (
    wr_ctrl |=> o_drive.span_supply[0] == $past(i_sfr_wdata[BIT_SPAN0]))
    else $error("converter 0 span does not follow control");
  AST_ZERO_FORCE: assert property (
    wr_ctrl |=> o_drive.zero_force == ~$past(i_sfr_wdata[BIT_OUTPUT_ZERO_FORCE_ONE:BIT_OUTPUT_ZERO_FORCE_ZERO]))
    else $error("clear bits not reflected as zero force");
  // the low byte sits in bits 7..0 only in 12-bit mode, so the check is kept to that mode
  AST_FOLLOW_LOW1: assert property (
    s_r.control[BIT_SYNC] && !s_r.control[BIT_MODE8] && wr_low1 ##1 !i_sfr_wr [*2]
    |-> $stable(o_drive.code1) && o_drive.code1[7:0] == s_r.low1)
    else $error("converter 1 output not following its low byte");
  AST_HOLD_WHILE_STAGED: assert property (
    !s_r.control[BIT_SYNC] && i_sfr_wr && !wr_ctrl |=> $stable(o_drive.code0)
    && $stable(o_drive.code1))
    else $error("output moved while updates were staged");
  AST_SIMULTANEOUS: assert property (
    sync_rise && !i_sfr_wdata[BIT_MODE8]
    |=> o_drive.code0 == {$past(s_r.high0[3:0]), $past(s_r.low0)}
    && o_drive.code1 == {$past(s_r.high1[3:0]), $past(s_r.low1)})
    else $error("staged codes not applied together");
  AST_POWER: assert property (
    wr_ctrl |=> o_drive.power_on == $past(i_sfr_wdata[BIT_PWR1:BIT_PWR0])
    && o_drive.out_enable == o_drive.power_on)
    else $error("power bits not applied");
  AST_STAY_OFF: assert property (
    o_drive.power_on == 2'h0 && !wr_ctrl |=> o_drive.out_enable == 2'h0)
    else $error("converter enabled without a control write");
  AST_HIGH_NIBBLE_IGNORED: assert property (
    s_r.control[BIT_SYNC] && !s_r.control[BIT_MODE8] && wr_low0
    |=> o_drive.code0[11:8] == $past(s_r.high0[3:0]))
    else $error("high nibble handling wrong");
  AST_BYPASS_REF_ONLY: assert property (
    o_drive.bypass[0] |-> !o_drive.span_supply[0])
    else $error("bypass active on supply span");
  AST_BYPASS_REF_ONE: assert property (
    o_drive.bypass[1] |-> !o_drive.span_supply[1])
    else $error("converter 1 bypass active on supply span");
  AST_BYPASS_FOLLOWS: assert property (
    i_buffer_bypass && !s_r.control[BIT_SPAN0] && !wr_ctrl |=> o_drive.bypass[0])
    else $error("converter 0 bypass not applied on reference span");
  AST_HIGH_WRITE_HOLDS: assert property (
    i_sfr_wr && (i_sfr_addr == ADDR_CODE0_HIGH) |=> $stable(o_drive.code0))
    else $error("high byte write moved converter 0 output");
  AST_CODE1_12BIT: assert property (
    s_r.control[BIT_SYNC] && !s_r.control[BIT_MODE8] && wr_low1
    |=> o_drive.code1 == {$past(s_r.high1[3:0]), $past(i_sfr_wdata)})
    else $error("converter 1 code not right-justified");
  AST_SYNC_EIGHT_BIT: assert property (
    sync_rise && i_sfr_wdata[BIT_MODE8]
    |=> o_drive.code0 == {$past(s_r.low0), 4'h0}
    && o_drive.code1 == {$past(s_r.low1), 4'h0})
    else $error("staged 8-bit codes not applied together");
  // rewriting an already set sync bit must not replay staged bytes
  AST_NO_RELOAD: assert property (
    wr_ctrl && s_r.control[BIT_SYNC] |=> $stable(o_drive.code0) && $stable(o_drive.code1))
    else $error("control write reloaded codes with sync already set");
  AST_OE_IS_POWER: assert property (
    o_drive.out_enable == o_drive.power_on)
    else $error("output enabled while converter powered down");
  AST_READ_CONTROL: assert property (
    i_sfr_addr == ADDR_CONTROL |=> o_sfr_rdata == $past(s_r.control))
    else $error("control read back wrong");
  AST_UNMAPPED_READ: assert property (
    i_sfr_addr < ADDR_CODE0_LOW |=> o_sfr_rdata == UNMAPPED_READ)
    else $error("unmapped read not zero");

  COV_LOW_WRITE: cover property (s_r.control[BIT_SYNC] && wr_low0 ##1 o_drive.power_on[0]);
  COV_NO_RELOAD: cover property (wr_ctrl && s_r.control[BIT_SYNC] && i_sfr_wdata[BIT_SYNC]);
  COV_SYNC_RISE: cover property (!s_r.control[BIT_SYNC] && wr_low1 ##[1:4] sync_rise);
  COV_EIGHT_BIT: cover property (s_r.control[BIT_MODE8] && wr_low1);
  COV_BYPASS: cover property (o_drive.bypass == 2'h3);
endmodule // dual_dac_register_control

// [dac_core_model.sv]
/*
  Behavioural model of the two analog converter cores and output buffers.
  Assumes the drive struct comes from the register control on i_core_clk.
*/
`timescale 1ns/1ns
module dac_core_model (
  input wire logic i_core_clk,
  input wire dac_ctrl_pkg::dac_drive_type i_drive,
  output logic [11:0] o_level0,
  output logic [11:0] o_level1
);
  import dac_ctrl_pkg::*;
  // a released output alternates between 12'hA5C and 12'h5A4 instead of holding a stale code
  logic [11:0] junk_r = 12'hA5C;
  always_ff @(posedge i_core_clk) begin
    junk_r <= ~junk_r + 12'h001;
  end
  always_comb begin
    o_level0 = i_drive.zero_force[0] ? 12'h000 : i_drive.code0;
    o_level1 = i_drive.zero_force[1] ? 12'h000 : i_drive.code1;
    if (!i_drive.out_enable[0]) o_level0 = junk_r;
    if (!i_drive.out_enable[1]) o_level1 = junk_r;
  end
endmodule // dac_core_model

// [dual_dac_register_control_tb.sv]
/*
  Self-checking bench for the dual converter register control.
  Assumes the converter core model sits on o_drive.
*/
`timescale 1ns/1ns
module dual_dac_register_control_tb;
  import dac_ctrl_pkg::*;
  typedef struct packed {
    logic [7:0] rd;
    logic [1:0] oe, sp, by;
    logic [11:0] l1, l0;
  } exp_type;
  logic clk, i_nrst, wr, byp, tok, tok_d, tok_dd;
  logic [7:0] addr, wdata, rdata;
  logic [11:0] l0, l1, c0, c1;
  logic [7:0] r [5];
  logic [31:0] seed;
  dac_drive_type drv;
  exp_type q [$];
  exp_type mx;
  int err_count, compares;
  logic [15:0] tbl [12] = '{16'hFD1F, 16'hFAF5, 16'hF923, 16'hFD1B, 16'hFA07, 16'hF989,
    16'hFC3C, 16'hFBDE, 16'hFD1F, 16'hFD9B, 16'hF9AB, 16'hFD9F};
  dual_dac_register_control i_dual_dac_register_control (.i_core_clk(clk), .i_nrst(i_nrst),
    .i_sfr_addr(addr), .i_sfr_wr(wr), .i_sfr_wdata(wdata), .i_buffer_bypass(byp),
    .o_sfr_rdata(rdata), .o_drive(drv));
  dac_core_model i_dac_core_model (.i_core_clk(clk), .i_drive(drv), .o_level0(l0),
    .o_level1(l1));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  function automatic logic [11:0] code(input logic m, input logic [7:0] h, input logic [7:0] l);
    return m ? {l, 4'h0} : {h[3:0], l};
  endfunction
  task automatic put_reg(input logic [7:0] a, input logic [7:0] d);
    if (a == ADDR_CONTROL && d[2] && !r[4][2]) begin
      c0 = code(d[7], r[1], r[0]);
      c1 = code(d[7], r[3], r[2]);
    end
    if (a == ADDR_CODE0_LOW && r[4][2]) c0 = code(r[4][7], r[1], d);
    if (a == ADDR_CODE1_LOW && r[4][2]) c1 = code(r[4][7], r[3], d);
    if (a >= ADDR_CODE0_LOW && a <= ADDR_CONTROL) r[a - ADDR_CODE0_LOW] = d;
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
  endtask
  task automatic get_reg(input logic [7:0] a);
    exp_type x;
    x.rd = (a >= ADDR_CODE0_LOW && a <= ADDR_CONTROL) ? r[a - ADDR_CODE0_LOW] : UNMAPPED_READ;
    x.oe = r[4][1:0];
    x.sp = r[4][6:5];
    x.by = {2{byp}} & ~r[4][6:5];
    x.l1 = r[4][4] ? c1 : 12'h000;
    x.l0 = r[4][3] ? c0 : 12'h000;
    q.push_back(x);
    wr <= 1'b0;
    addr <= a;
    tok <= ~tok;
    @(posedge clk);
  endtask
  task automatic chk(input exp_type seen, input exp_type exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // results lag the read request by two edges: address sample, then registered data
  always @(posedge clk) begin
    tok_d <= tok;
    tok_dd <= tok_d;
    if (tok_d !== tok_dd) begin
      mx = q.pop_front();
      chk({rdata, drv.out_enable, drv.span_supply, drv.bypass, mx.oe[1] ? l1 : mx.l1,
        mx.oe[0] ? l0 : mx.l0}, mx);
    end
  end
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    finish_test();
  end
  initial begin
    {i_nrst, wr, byp, tok, tok_d, tok_dd, addr, wdata, c0, c1} = '0;
    r = '{RESET_CODE_BYTE, RESET_CODE_BYTE, RESET_CODE_BYTE, RESET_CODE_BYTE, RESET_CONTROL};
    seed = 32'hF9293C3E;
    repeat (16) @(posedge clk);
    i_nrst <= 1'b1;
    repeat (3) @(posedge clk);
    for (int a = 8'hF8; a <= 8'hFF; a++) get_reg(8'(a));
    byp <= 1'b1;
    // high byte is written straight before its low byte, with no read between
    foreach (tbl[i]) begin
      put_reg(tbl[i][15:8], tbl[i][7:0]);
      if (tbl[i][15:8] != ADDR_CODE0_HIGH && tbl[i][15:8] != ADDR_CODE1_HIGH)
        get_reg(tbl[i][15:8]);
    end
    for (int i = 0; i < 60; i++) begin
      seed = xs(seed);
      byp <= seed[31];
      put_reg(8'hF8 + {5'h00, seed[2:0]}, seed[15:8]);
      get_reg(8'hF8 + {5'h00, seed[22:20]});
    end
    repeat (4) @(posedge clk);
    if (q.size() != 0) err_count++;
    finish_test();
  end
endmodule // dual_dac_register_control_tb
